// ===== core/fpr_readout.sv
/*
 * Top of the fingerprint image parallel readout block. Streams the image
 * over the host read-data handshake, handles dynamics, sleep and strap,
 * and exposes pixel loading and status over APB.
 * Assumes host pins are asynchronous and the pixel source writes through
 * APB one pixel per addressed column of the current line.
 */
// The APB interface to the registers and the register addresses were chosen for this implementation.
// Summary of operation
// - Pixel is 8-bit gray, 0 black
// - High or low dynamics selectable
// - Image is 288 lines of 224 bytes
// - Lines in order, pixels from one
// - Terminator byte 00h ends each line
// - Filler lines of FFh then 00h
// - Sleep state, immediate readout on wake
// - Strap at power-on picks interface
// - Internal power-up reset, none needed
// - Reset pin only in parallel mode
// - Only read-data cycle supported
// - Reset homes, sleeps, changes dynamics
// - Revision 1.9 handshake only
// - Request low, device drives, ready high
// - Request high, ready low, data floats
// - Image end clears dynamics to low
module fpr_readout
    import fpr_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host pins.
    input  wire logic        request_n,
    input  wire logic        host_reset_n,
    input  wire logic        interface_select_strap,
    output logic             ready,
    output logic      [7:0]  data_out,
    output logic      [7:0]  data_oe,
    // Analog front end controls.
    output logic             high_dynamics,
    output logic             sleep_active
);

    logic [2:0] pins_sync;
    logic       req_n_s;
    logic       rst_n_s;
    logic       strap_s;

    fpr_sync #(
        .WIDTH       (3),
        .RESET_VALUE (3'h6)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .async_in ({request_n, host_reset_n, interface_select_strap}),
        .sync_out (pins_sync)
    );

    assign req_n_s = pins_sync[2];
    assign rst_n_s = pins_sync[1];
    assign strap_s = pins_sync[0];

    // Internal power-up reset
    // The presetn input stands for the built-in power-on reset; the host
    // reset pin is a separate, optional control.
    logic       strapped_reg;
    logic       parallel_reg;
    logic [1:0] strap_wait_reg;

    // Strap latched once
    // The synchroniser shows its reset value for two edges after release,
    // so the strap is caught on the third enabled edge and then held,
    // since the interface may not change while powered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_wait_reg <= 2'h0;
            strapped_reg   <= 1'b0;
            parallel_reg   <= 1'b0;
        end else if (clk_en && !strapped_reg) begin
            if (strap_wait_reg == 2'h2) begin
                strapped_reg <= 1'b1;
                parallel_reg <= strap_s;
            end else begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end
        end
    end

    wire pin_rst_low  = parallel_reg && strapped_reg && !rst_n_s;
    logic rst_low_d_reg;
    wire pin_rst_fall = pin_rst_low && !rst_low_d_reg;
    wire pin_rst_rise = !pin_rst_low && rst_low_d_reg;

    // Sleep state: held reset beyond the pulse time.
    logic [8:0] low_cnt_reg;
    logic       sleep_reg;
    wire        low_long = (low_cnt_reg >= 9'(SLEEP_CYCLES));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_low_d_reg <= 1'b0;
            low_cnt_reg   <= 9'h000;
            sleep_reg     <= 1'b0;
        end else if (clk_en) begin
            rst_low_d_reg <= pin_rst_low;
            if (!pin_rst_low) begin
                low_cnt_reg <= 9'h000;
            end else if (!low_long) begin
                low_cnt_reg <= low_cnt_reg + 9'h001;
            end
            sleep_reg <= pin_rst_low && low_long;
        end
    end

    // Dynamics: each reset rising after a low-dynamics reset raises it.
    logic dyn_reg;
    logic armed_reg;
    logic image_done;

    // Dynamics cleared at image end
    // The first reset after the image end only homes the pointer and arms
    // the next one, which raises dynamics; resets never lower it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dyn_reg   <= 1'b0;
            armed_reg <= 1'b0;
        end else if (clk_en) begin
            if (image_done) begin
                dyn_reg   <= 1'b0;
                armed_reg <= 1'b0;
            end else if (pin_rst_rise) begin
                if (armed_reg) begin
                    dyn_reg <= 1'b1;
                end
                armed_reg <= 1'b1;
            end
        end
    end

    // APB gain override lets software force high dynamics in serial mode.
    logic [31:0] ctrl_reg;
    assign high_dynamics = dyn_reg || ctrl_reg[CTRL_GAIN_BIT];
    assign sleep_active  = sleep_reg;

    // Pointer.
    logic [8:0] line_reg;
    logic [7:0] col_reg;
    logic       filler_reg;
    logic       advance;

    fpr_pixel_ptr u_ptr (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .home       (pin_rst_fall),
        .advance    (advance),
        .line_reg   (line_reg),
        .col_reg    (col_reg),
        .filler_reg (filler_reg),
        .image_done (image_done)
    );

    // Line buffer of one line of pixels, loaded by software.
    logic [7:0] line_mem [NUM_COLS];

    // Byte selection for the current pointer.
    wire       at_term    = (col_reg == LAST_COL);
    wire [7:0] pixel_byte = line_mem[col_reg];
    wire [7:0] next_byte;
    assign next_byte = at_term    ? LINE_TERM_VALUE :
                       filler_reg ? FILLER_VALUE    :
                                    pixel_byte;

    // Handshake engine.
    fpr_hs_state_t state_reg;
    fpr_hs_state_t state_next;
    logic [7:0]    wait_cnt_reg;
    logic [7:0]    data_reg;
    logic          drive_reg;
    wire           can_serve = parallel_reg && strapped_reg && !sleep_reg && !pin_rst_low;
    wire           wait_over = (wait_cnt_reg == 8'(READY_CYCLES - 1));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            HS_IDLE: begin
                if (!req_n_s && can_serve) begin
                    state_next = HS_WAIT;
                end
            end
            HS_WAIT: begin
                if (wait_over) begin
                    state_next = HS_READY;
                end
            end
            HS_READY: begin
                if (req_n_s) begin
                    state_next = HS_DONE;
                end
            end
            HS_DONE: begin
                state_next = HS_IDLE;
            end
            default: begin
                state_next = HS_IDLE;
            end
        endcase
    end

    assign advance = (state_reg == HS_DONE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= HS_IDLE;
            wait_cnt_reg <= 8'h00;
            data_reg     <= 8'h00;
            drive_reg    <= 1'b0;
        end else if (clk_en) begin
            state_reg    <= (pin_rst_low || !parallel_reg) ? HS_IDLE : state_next;
            wait_cnt_reg <= (state_reg == HS_WAIT) ? wait_cnt_reg + 8'h01 : 8'h00;
            if (state_reg == HS_IDLE && state_next == HS_WAIT) begin
                data_reg  <= next_byte;
                drive_reg <= 1'b1;
            end else if (state_next == HS_DONE || state_next == HS_IDLE) begin
                drive_reg <= 1'b0;
            end
        end
    end

    assign ready    = (state_reg == HS_READY);
    assign data_out = data_reg;
    assign data_oe  = {8{drive_reg}};

    // APB slave: zero wait states.
    wire apb_access = psel && penable;
    wire apb_wr     = apb_access && pwrite;
    wire sel_ctrl   = (paddr == ADDR_CTRL);
    wire sel_status = (paddr == ADDR_STATUS);
    wire sel_ptr    = (paddr == ADDR_POINTER);
    wire sel_pixel  = (paddr == ADDR_PIXEL);
    wire mapped     = sel_ctrl || sel_status || sel_ptr || sel_pixel;

    // Pixel writes carry the column in bits 15:8 and the value in bits 7:0.
    wire [7:0] wr_col  = pwdata[15:8];
    wire       col_ok  = (wr_col < LAST_COL);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET_VALUE;
        end else if (clk_en && apb_wr && sel_ctrl) begin
            ctrl_reg <= {31'h0000_0000, pwdata[CTRL_GAIN_BIT]};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_COLS; gi++) begin : g_line
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    line_mem[gi] <= 8'h00;
                end else if (clk_en && apb_wr && sel_pixel && col_ok && wr_col == 8'(gi)) begin
                    line_mem[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    wire [31:0] status_word = {26'h000_0000, strapped_reg, ready, filler_reg,
                               parallel_reg, sleep_reg, dyn_reg};
    wire [31:0] rd_mux = sel_ctrl   ? ctrl_reg :
                         sel_status ? status_word :
                         sel_ptr    ? {15'h0000, line_reg, col_reg} :
                                      32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = apb_access && !mapped;

endmodule

// ===== core/fpr_pkg.sv
/*
 * Shared constants for the fingerprint image parallel readout block:
 * image geometry, byte values, handshake and sleep timing, APB map.
 * Assumes a 125 MHz pclk and a 32-bit APB slave interface.
 */
package fpr_pkg;

    // Clock and timing.
    localparam int unsigned CLK_MHZ          = 125;
    localparam int unsigned SLEEP_PULSE_NS   = 2000;
    localparam int unsigned SLEEP_CYCLES     = (SLEEP_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned READY_DELAY_NS   = 600;
    localparam int unsigned READY_CYCLES     = (READY_DELAY_NS * CLK_MHZ) / 1000;

    // Image geometry.
    localparam int unsigned NUM_LINES        = 288;
    localparam int unsigned NUM_COLS         = 224;
    localparam logic [8:0]  LAST_LINE        = 9'h11f;
    localparam logic [7:0]  LAST_COL         = 8'he0;

    // Byte values.
    localparam logic [7:0]  LINE_TERM_VALUE  = 8'h00;
    localparam logic [7:0]  FILLER_VALUE     = 8'hff;

    // APB register map, byte addresses.
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_STATUS      = 8'h04;
    localparam logic [7:0]  ADDR_POINTER     = 8'h08;
    localparam logic [7:0]  ADDR_PIXEL       = 8'h0c;

    // Control fields.
    localparam int unsigned CTRL_GAIN_BIT    = 0;
    localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0000;

    // Status fields.
    localparam int unsigned ST_DYN_BIT       = 0;
    localparam int unsigned ST_SLEEP_BIT     = 1;
    localparam int unsigned ST_PARALLEL_BIT  = 2;
    localparam int unsigned ST_FILLER_BIT    = 3;
    localparam int unsigned ST_READY_BIT     = 4;
    localparam int unsigned ST_STRAPPED_BIT  = 5;

    // Handshake states.
    typedef enum logic [3:0] {
        HS_IDLE  = 4'b0001,
        HS_WAIT  = 4'b0010,
        HS_READY = 4'b0100,
        HS_DONE  = 4'b1000
    } fpr_hs_state_t;

endpackage

// ===== core/fpr_sync.sv
/*
 * Two flip-flop synchroniser for a group of asynchronous pin inputs.
 * Assumes the inputs are static long enough to be sampled at pclk.
 */
module fpr_sync
    import fpr_pkg::*;
#(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    // Data.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= RESET_VALUE;
            sync_out   <= RESET_VALUE;
        end else if (clk_en) begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end

endmodule

// ===== core/fpr_pixel_ptr.sv
/*
 * Byte pointer over the readout stream: line, column and filler state.
 * Assumes one advance pulse per completed read and a synchronous home.
 */
module fpr_pixel_ptr
    import fpr_pkg::*;
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    // Control.
    input  wire logic       home,
    input  wire logic       advance,
    // State.
    output logic      [8:0] line_reg,
    output logic      [7:0] col_reg,
    output logic            filler_reg,
    output logic            image_done
);

    wire at_term   = (col_reg == LAST_COL);
    wire last_line = (line_reg == LAST_LINE);

    // Final byte of the image is the terminator of the last line.
    assign image_done = advance && at_term && last_line && !filler_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_reg   <= 9'h000;
            col_reg    <= 8'h00;
            filler_reg <= 1'b0;
        end else if (clk_en) begin
            if (home) begin
                line_reg   <= 9'h000;
                col_reg    <= 8'h00;
                filler_reg <= 1'b0;
            end else if (advance) begin
                if (!at_term) begin
                    col_reg <= col_reg + 8'h01;
                end else begin
                    col_reg <= 8'h00;
                    if (last_line) begin
                        filler_reg <= 1'b1;
                    end else if (!filler_reg) begin
                        line_reg <= line_reg + 9'h001;
                    end
                end
            end
        end
    end

endmodule

// ===== tb/fpr_readout_asserts.sv
/*
 * Checker for the readout block: host handshake, sleep, strap and APB error.
 * Assumes it is bound to fpr_readout and sees only that module's ports.
 */
module fpr_readout_asserts
    import fpr_pkg::*;
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // APB.
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic [7:0] paddr,
    input  wire logic       pslverr,
    // Host pins.
    input  wire logic       request_n,
    input  wire logic       host_reset_n,
    input  wire logic       interface_select_strap,
    input  wire logic       ready,
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] data_oe,
    input  wire logic       sleep_active
);
    logic [9:0] low_cnt_reg;
    logic [9:0] low_cnt_next;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Saturates so that a very long low pin never wraps back to a short count.
    assign low_cnt_next = host_reset_n ? 10'h000 : low_cnt_reg + {9'h000, ~&low_cnt_reg};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_reg <= 10'h000;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end

    oe_on_ready_a: assert property (ready |-> data_oe == 8'hff)
        else $error("data lines not driven while ready is high");
    ready_latency_a: assert property ($fell(request_n) && interface_select_strap
        && host_reset_n && !sleep_active |-> ##[70:85] ready)
        else $error("ready did not follow the request in time");
    ready_hold_a: assert property (ready && !request_n && host_reset_n |=> ready)
        else $error("ready dropped while the request was still low");
    data_hold_a: assert property (ready ##1 ready |-> $stable(data_out))
        else $error("data changed while ready was high");
    ready_drop_a: assert property ($rose(request_n) |-> ##[1:4] (!ready && data_oe == 8'h00))
        else $error("ready or data lines not released after the request");
    sleep_entry_a: assert property (interface_select_strap && low_cnt_reg == 10'h10e
        |-> sleep_active)
        else $error("long reset pulse did not enter sleep");
    sleep_exit_a: assert property (host_reset_n [*8] |-> !sleep_active)
        else $error("sleep held with the reset pin high");
    sleep_quiet_a: assert property (sleep_active |-> !ready)
        else $error("ready raised while asleep");
    serial_quiet_a: assert property (!interface_select_strap |-> !ready && !sleep_active)
        else $error("parallel activity with the strap low");
    apb_error_a: assert property (psel && penable && paddr[1:0] == 2'b00
        |-> pslverr == (paddr > ADDR_PIXEL))
        else $error("bus error flag wrong for the address");
endmodule

bind fpr_readout fpr_readout_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pslverr(pslverr), .request_n(request_n), .host_reset_n(host_reset_n),
    .interface_select_strap(interface_select_strap), .ready(ready),
    .data_out(data_out), .data_oe(data_oe), .sleep_active(sleep_active));

// ===== tb/fpr_host_model.sv
/*
 * Behavioural host port that reads one byte per strobe and drives the reset pin.
 * Assumes its tasks are called right after a rising pclk edge.
 */
module fpr_host_model
    import fpr_pkg::*;
(
    // Clock.
    input  wire logic       pclk,
    // Device side.
    input  wire logic       ready,
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] data_oe,
    // Host strobes.
    output logic            request_n,
    output logic            host_reset_n
);
    logic [7:0] bus;

    // A released line shows the inverse of its last value, so stale data cannot pass.
    assign bus = (data_out & data_oe) | (~data_out & ~data_oe);

    initial begin
        request_n    = 1'b1;
        host_reset_n = 1'b1;
    end

    task automatic set_reset(input logic level);
        host_reset_n <= level;
    endtask

    task automatic read_byte(input int hold, output logic [7:0] b, output logic ok);
        int n;
        request_n <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (ready !== 1'b1 && n < 200);
        b  = bus;
        ok = n < 200;
        repeat (hold) @(posedge pclk);
        request_n <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (ready !== 1'b0 && n < 20);
        ok = ok && n < 20;
        @(posedge pclk);
    endtask
endmodule

// ===== tb/testbench.sv
/*
 * Self-checking bench: registers, one image line, pointer home, dynamics,
 * sleep and the serial strap.
 * Assumes the package, design, checker and host model are compiled first.
 */
module testbench
    import fpr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        clk_en;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        request_n;
    logic        host_reset_n;
    logic        interface_select_strap;
    logic        ready;
    logic [7:0]  data_out;
    logic [7:0]  data_oe;
    logic        high_dynamics;
    logic        sleep_active;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  rb;
    logic        ok;
    int          bad_count = 0;
    int          num_checks = 0;

    fpr_readout u_dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .request_n(request_n), .host_reset_n(host_reset_n),
        .interface_select_strap(interface_select_strap), .ready(ready),
        .data_out(data_out), .data_oe(data_oe), .high_dynamics(high_dynamics),
        .sleep_active(sleep_active));

    fpr_host_model u_host (
        .pclk(pclk), .ready(ready), .data_out(data_out), .data_oe(data_oe),
        .request_n(request_n), .host_reset_n(host_reset_n));

    always #4 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [7:0] pix(input int c);
        return (c == NUM_COLS - 1) ? 8'hff : c[7:0];
    endfunction

    task automatic pulse(input int len);
        u_host.set_reset(1'b0);
        repeat (len) @(posedge pclk);
        u_host.set_reset(1'b1);
        repeat (8) @(posedge pclk);
    endtask

    task automatic test_done();
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset values, an unmapped address and the forced dynamics bit.
    task automatic t_regs();
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, CTRL_RESET_VALUE);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_0024);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, ADDR_CTRL, 32'h1);
        chk(high_dynamics, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        chk(high_dynamics, 1'b0);
    endtask

    // One whole line with its terminator, then the first byte of line two.
    task automatic t_line();
        for (int c = 0; c < NUM_COLS; c++) begin
            apb(1'b1, ADDR_PIXEL, {16'h0, c[7:0], pix(c)});
        end
        for (int c = 0; c <= NUM_COLS; c++) begin
            u_host.read_byte(c % 3, rb, ok);
            chk({ok, rb}, {1'b1, (c < NUM_COLS) ? pix(c) : LINE_TERM_VALUE});
        end
        u_host.read_byte(0, rb, ok);
        chk({ok, rb}, {1'b1, pix(0)});
        apb(1'b0, ADDR_POINTER, 32'h0);
        chk(rd, 32'h0000_0101);
    endtask

    // Short pulses: the first homes the pointer only, the second raises dynamics.
    task automatic t_dyn();
        pulse(20);
        apb(1'b0, ADDR_POINTER, 32'h0);
        chk(rd, 32'h0);
        chk(high_dynamics, 1'b0);
        pulse(20);
        chk(high_dynamics, 1'b1);
        u_host.read_byte(1, rb, ok);
        chk({ok, rb}, {1'b1, pix(0)});
    endtask

    task automatic t_sleep();
        u_host.set_reset(1'b0);
        repeat (270) @(posedge pclk);
        chk(sleep_active, 1'b1);
        u_host.read_byte(0, rb, ok);
        chk(ok, 1'b0);
        u_host.set_reset(1'b1);
        repeat (8) @(posedge pclk);
        chk(sleep_active, 1'b0);
        u_host.read_byte(0, rb, ok);
        chk({ok, rb}, {1'b1, pix(0)});
    endtask

    // Power cycle with the strap low, then move the strap: the mode must not follow.
    task automatic t_serial();
        presetn                <= 1'b0;
        interface_select_strap <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_0020);
        u_host.read_byte(0, rb, ok);
        chk(ok, 1'b0);
        interface_select_strap <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_0020);
    endtask

    initial begin
        pclk                   = 1'b0;
        presetn                = 1'b0;
        clk_en                 = 1'b1;
        psel                   = 1'b0;
        penable                = 1'b0;
        pwrite                 = 1'b0;
        paddr                  = 8'h00;
        pwdata                 = 32'h0;
        interface_select_strap = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_regs();
        t_line();
        t_dyn();
        t_sleep();
        t_serial();
        test_done();
    end

    // About twice the expected run length.
    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        test_done();
    end
endmodule
